// *** logic/txp_cfg.svh ***
`ifndef TXP_CFG_SVH
`define TXP_CFG_SVH

// register byte addresses
`define TXP_ADDR_W 8
`define TXP_ADDR_CTRL 8'h00
`define TXP_ADDR_STATUS 8'h04
`define TXP_ADDR_INT_STATUS 8'h08
`define TXP_ADDR_INT_CLEAR 8'h0C
`define TXP_ADDR_INT_ENABLE 8'h10

// field positions and reset values
`define TXP_CTRL_W 4
`define TXP_CTRL_RESET 4'h8
`define TXP_INIT_BIT 3
`define TXP_INT_W 2
`define TXP_INT_EN_RESET 2'h0
`define TXP_STAT_ERR_BIT 0
`define TXP_STAT_LVL_LSB 4

// axi responses
`define TXP_RESP_OKAY 2'h0
`define TXP_RESP_SLVERR 2'h2

// character path constants
`define TXP_CHAR_W 10
`define TXP_ERR_CHAR 10'h278
`define TXP_MULT_W 5
`define TXP_MULT_FULL 5'h0A
`define TXP_MULT_HALF 5'h14
`define TXP_LFSR_SEED 9'h1FF
`define TXP_LFSR_MSB 8
`define TXP_LFSR_TAP 4

`endif

// *** logic/txp_pkg.sv ***
package txp_pkg;

  // control register layout, high bit first, init latch is bit 3
  typedef struct packed {
    logic init_latch;
    logic selftest;
    logic rate_sel;
    logic clk_sel;
  } txp_ctrl_t;

  // interrupt status, clear and enable layout
  typedef struct packed {
    logic init_done;
    logic phase_err;
  } txp_int_t;

  // source of the outgoing character
  typedef enum logic [1:0] {
    txp_mode_buf,
    txp_mode_bypass,
    txp_mode_selftest
  } txp_mode_t;

endpackage : txp_pkg

// *** logic/txp_pin_sync.sv ***
module txp_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // asynchronous pins
  input wire logic [W-1:0] pin_i,
  // filtered levels
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;

  // three stages, a level counts once stages two and three agree
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg <= '0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  assign q_o = q_reg;

endmodule : txp_pin_sync

// *** logic/txp_lfsr.sv ***
`include "txp_cfg.svh"

module txp_lfsr #(
  parameter logic [`TXP_LFSR_MSB:0] SEED = `TXP_LFSR_SEED
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic en_i,
  input wire logic step_i,
  // pattern character
  output logic [`TXP_CHAR_W-1:0] char_o
);

  logic [`TXP_LFSR_MSB:0] q_reg;
  logic fb;

  // nine stage maximal length feedback
  assign fb = q_reg[`TXP_LFSR_MSB] ^ q_reg[`TXP_LFSR_TAP];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q_reg <= SEED;
    end else if (!en_i) begin
      q_reg <= SEED;
    end else if (step_i) begin
      q_reg <= {q_reg[`TXP_LFSR_MSB-1:0], fb};
    end
  end

  assign char_o = {q_reg, fb};

  lfsr_nonzero_a : assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    en_i |-> q_reg != '0)
    else $error("pattern register locked at zero");

endmodule : txp_lfsr

// *** logic/txp_top.sv ***
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`include "txp_cfg.svh"

// Summary of operation
// - capture on host clock or reference clock
// - buffer used for host or half-rate capture
// - full-rate reference capture bypasses the buffer
// - error raised on slip, held until init
// - writing init latch zero restarts the buffer
// - error drops only after buffer init
// - error character sent while error stands, except in self-test where the pattern is sent
// - self-test turns register into pattern generator
// - reset leaves self-test disabled
// - parallel inputs ignored during self-test
// - rate select picks multiply by ten or twenty
module txp_top #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // axi4-lite write address
  input wire logic [`TXP_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read address
  input wire logic [`TXP_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // host parallel pins
  input wire logic [`TXP_CHAR_W-1:0] tx_char_in_i,
  input wire logic tx_host_input_clock_i,
  input wire logic tx_reference_clock_i,
  // character path and status
  output logic [`TXP_CHAR_W-1:0] tx_char_o,
  output logic tx_char_stb_o,
  output logic tx_phase_error_o,
  output logic [`TXP_MULT_W-1:0] tx_pll_mult_o,
  output logic irq_o
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CENTER = (AW + 1)'(DEPTH / 2);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  txp_pkg::txp_ctrl_t ctrl_reg;
  txp_pkg::txp_int_t int_stat_reg;
  txp_pkg::txp_int_t int_en_reg;
  txp_pkg::txp_int_t int_set;
  txp_pkg::txp_int_t int_clr;
  txp_pkg::txp_mode_t mode;

  logic [1:0] clk_q;
  logic [`TXP_CHAR_W-1:0] data_q;
  logic host_prev_reg;
  logic ref_prev_reg;
  logic host_rise;
  logic ref_rise;
  logic ref_fall;
  logic char_stb;
  logic cap_stb;
  logic fifo_wr;
  logic fifo_rd;
  logic ovf;
  logic unf;
  logic [`TXP_CHAR_W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] level_reg;
  logic err_reg;
  logic init_pulse_reg;
  logic [`TXP_CHAR_W-1:0] lfsr_char;
  logic [`TXP_CHAR_W-1:0] char_reg;
  logic char_stb_reg;
  logic [`TXP_MULT_W-1:0] mult_reg;
  logic irq_reg;
  logic [31:0] status_word;

  logic awready_reg;
  logic wready_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [`TXP_ADDR_W-1:0] aw_addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_fire;

  // pin synchronisers
  txp_pin_sync #(
    .W(2)
  ) u_clk_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i({tx_reference_clock_i, tx_host_input_clock_i}),
    .q_o(clk_q)
  );

  txp_pin_sync #(
    .W(`TXP_CHAR_W)
  ) u_data_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(tx_char_in_i),
    .q_o(data_q)
  );

  // edge detection on the filtered clocks
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_prev_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
    end else begin
      host_prev_reg <= clk_q[0];
      ref_prev_reg <= clk_q[1];
    end
  end

  assign host_rise = clk_q[0] & ~host_prev_reg;
  assign ref_rise = clk_q[1] & ~ref_prev_reg;
  assign ref_fall = ~clk_q[1] & ref_prev_reg;
  // half-rate reference yields two characters per period
  assign char_stb = ref_rise | (ctrl_reg.rate_sel & ref_fall);
  assign cap_stb = ctrl_reg.clk_sel ? char_stb : host_rise;

  // path selection
  always_comb begin
    if (ctrl_reg.selftest) begin
      mode = txp_pkg::txp_mode_selftest;
    end else if (ctrl_reg.clk_sel && !ctrl_reg.rate_sel) begin
      mode = txp_pkg::txp_mode_bypass;
    end else begin
      mode = txp_pkg::txp_mode_buf;
    end
  end

  assign fifo_wr = cap_stb && (mode == txp_pkg::txp_mode_buf);
  assign fifo_rd = char_stb && (mode == txp_pkg::txp_mode_buf);
  assign ovf = fifo_wr && !fifo_rd && (level_reg == FULL);
  assign unf = fifo_rd && (level_reg == '0);

  // phase-align buffer pointers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= CENTER[AW-1:0];
      rd_ptr_reg <= '0;
      level_reg <= CENTER;
    end else if (init_pulse_reg) begin
      wr_ptr_reg <= CENTER[AW-1:0];
      rd_ptr_reg <= '0;
      level_reg <= CENTER;
    end else begin
      if (fifo_wr && !ovf) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (fifo_rd && !unf) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      case ({fifo_wr && !ovf, fifo_rd && !unf})
        2'b10: level_reg <= level_reg + 1'b1;
        2'b01: level_reg <= level_reg - 1'b1;
        default: level_reg <= level_reg;
      endcase
    end
  end

  // buffer storage
  always_ff @(posedge clk_i) begin
    if (fifo_wr && !ovf) begin
      mem_reg[wr_ptr_reg] <= data_q;
    end
  end

  // sticky phase error
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      err_reg <= 1'b0;
    end else if (init_pulse_reg) begin
      err_reg <= 1'b0;
    end else if (ovf || unf) begin
      err_reg <= 1'b1;
    end
  end

  // pattern generator
  txp_lfsr u_lfsr (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .en_i(ctrl_reg.selftest),
    .step_i(char_stb),
    .char_o(lfsr_char)
  );

  // outgoing character
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      char_reg <= '0;
      char_stb_reg <= 1'b0;
    end else begin
      char_stb_reg <= char_stb;
      if (char_stb) begin
        case (mode)
          txp_pkg::txp_mode_selftest: char_reg <= lfsr_char;
          txp_pkg::txp_mode_bypass: char_reg <= err_reg ? `TXP_ERR_CHAR : data_q;
          txp_pkg::txp_mode_buf: begin
            if (err_reg || unf) begin
              char_reg <= `TXP_ERR_CHAR;
            end else begin
              char_reg <= mem_reg[rd_ptr_reg];
            end
          end
          default: char_reg <= `TXP_ERR_CHAR;
        endcase
      end
    end
  end

  // multiplier setting
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mult_reg <= `TXP_MULT_FULL;
    end else begin
      mult_reg <= ctrl_reg.rate_sel ? `TXP_MULT_HALF : `TXP_MULT_FULL;
    end
  end

  // axi write channels
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `TXP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && awready_reg) begin
        aw_addr_reg <= s_axi_awaddr_i;
        aw_have_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid_i && wready_reg) begin
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
        w_have_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        case (aw_addr_reg)
          `TXP_ADDR_CTRL, `TXP_ADDR_STATUS, `TXP_ADDR_INT_STATUS,
          `TXP_ADDR_INT_CLEAR, `TXP_ADDR_INT_ENABLE: bresp_reg <= `TXP_RESP_OKAY;
          default: bresp_reg <= `TXP_RESP_SLVERR;
        endcase
      end
      if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // control register and init strobe
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= txp_pkg::txp_ctrl_t'(`TXP_CTRL_RESET);
      init_pulse_reg <= 1'b0;
    end else begin
      init_pulse_reg <= 1'b0;
      if (wr_fire && aw_addr_reg == `TXP_ADDR_CTRL && wstrb_reg[0]) begin
        ctrl_reg <= txp_pkg::txp_ctrl_t'(wdata_reg[`TXP_CTRL_W-1:0]);
        init_pulse_reg <= !wdata_reg[`TXP_INIT_BIT];
      end
    end
  end

  // interrupts
  assign int_set.phase_err = (ovf || unf) && !err_reg && !init_pulse_reg;
  assign int_set.init_done = init_pulse_reg;
  assign int_clr = (wr_fire && aw_addr_reg == `TXP_ADDR_INT_CLEAR && wstrb_reg[0]) ?
                   txp_pkg::txp_int_t'(wdata_reg[`TXP_INT_W-1:0]) : '0;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      int_stat_reg <= '0;
    end else begin
      int_stat_reg <= int_set | (int_stat_reg & ~int_clr);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      int_en_reg <= txp_pkg::txp_int_t'(`TXP_INT_EN_RESET);
    end else if (wr_fire && aw_addr_reg == `TXP_ADDR_INT_ENABLE && wstrb_reg[0]) begin
      int_en_reg <= txp_pkg::txp_int_t'(wdata_reg[`TXP_INT_W-1:0]);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(int_stat_reg & int_en_reg);
    end
  end

  // axi read channels
  always_comb begin
    status_word = '0;
    status_word[`TXP_STAT_ERR_BIT] = err_reg;
    status_word[`TXP_STAT_LVL_LSB +: AW + 1] = level_reg;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= `TXP_RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= `TXP_RESP_OKAY;
      case (s_axi_araddr_i)
        `TXP_ADDR_CTRL: rdata_reg <= {28'h0000000, ctrl_reg};
        `TXP_ADDR_STATUS: rdata_reg <= status_word;
        `TXP_ADDR_INT_STATUS: rdata_reg <= {30'h00000000, int_stat_reg};
        `TXP_ADDR_INT_ENABLE: rdata_reg <= {30'h00000000, int_en_reg};
        `TXP_ADDR_INT_CLEAR: rdata_reg <= '0;
        default: begin
          rdata_reg <= '0;
          rresp_reg <= `TXP_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign tx_char_o = char_reg;
  assign tx_char_stb_o = char_stb_reg;
  assign tx_phase_error_o = err_reg;
  assign tx_pll_mult_o = mult_reg;
  assign irq_o = irq_reg;

  capture_clock_a : assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    fifo_wr |-> (ctrl_reg.clk_sel ? char_stb : host_rise))
    else $error("buffer written off the selected capture clock");

  buffer_path_a : assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (fifo_rd || fifo_wr) |-> (!ctrl_reg.clk_sel || ctrl_reg.rate_sel))
    else $error("buffer used with full-rate reference capture");

  bypass_char_a : assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    char_stb && mode == txp_pkg::txp_mode_bypass && !err_reg
    |=> tx_char_o == $past(data_q))
    else $error("bypass character not passed straight through");

  err_hold_a : assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    err_reg && !init_pulse_reg |=> tx_phase_error_o)
    else $error("phase error dropped without buffer init");

  init_restart_a : assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    init_pulse_reg |=> level_reg == CENTER && rd_ptr_reg == '0)
    else $error("buffer not centred after init");

  err_release_a : assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $fell(tx_phase_error_o) |-> $past(init_pulse_reg))
    else $error("phase error cleared without init");

  err_char_a : assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    char_stb && err_reg && !ctrl_reg.selftest |=> tx_char_o == `TXP_ERR_CHAR)
    else $error("error character not sent during phase error");

  selftest_char_a : assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    char_stb && ctrl_reg.selftest |=> tx_char_o == $past(lfsr_char))
    else $error("self-test character not from pattern generator");

  selftest_reset_a : assert property (
    @(posedge clk_i)
    $past(sys_rst_i) |-> !ctrl_reg.selftest)
    else $error("self-test enabled after reset");

  input_ignore_a : assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    ctrl_reg.selftest && !init_pulse_reg |=> $stable(level_reg) && $stable(wr_ptr_reg))
    else $error("parallel input used during self-test");

  mult_select_a : assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    ctrl_reg.rate_sel ##1 ctrl_reg.rate_sel |-> tx_pll_mult_o == `TXP_MULT_HALF)
    else $error("multiplier does not follow rate select");

  level_bound_a : assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    level_reg <= FULL)
    else $error("buffer level beyond depth");

  bresp_hold_a : assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before taken");

endmodule : txp_top

// *** tb/txp_host_model.sv ***
module txp_host_model #(
  parameter int REF_HALF = 6
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // host clock half period in clk cycles, zero stops the host clock
  input wire logic [3:0] host_half_i,
  // pins toward the device
  output logic [9:0] tx_char_in_o,
  output logic tx_host_input_clock_o,
  output logic tx_reference_clock_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int ref_cnt;
  int host_cnt;
  // reference clock runs free
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ref_cnt <= 0;
      tx_reference_clock_o <= 1'b0;
    end else if (ref_cnt == REF_HALF - 1) begin
      ref_cnt <= 0;
      tx_reference_clock_o <= !tx_reference_clock_o;
    end else begin
      ref_cnt <= ref_cnt + 1;
    end
  end
  // host clock at the reference rate keeps zero drift; data moves on its falling edge
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_cnt <= 0;
      tx_host_input_clock_o <= 1'b0;
      tx_char_in_o <= 10'h000;
    end else if (host_half_i != 4'h0) begin
      if (host_cnt >= int'(host_half_i) - 1) begin
        host_cnt <= 0;
        tx_host_input_clock_o <= !tx_host_input_clock_o;
        if (tx_host_input_clock_o) tx_char_in_o <= tx_char_in_o + 10'h001;
      end else begin
        host_cnt <= host_cnt + 1;
      end
    end
  end
endmodule : txp_host_model

// *** tb/test_tx_parallel_input_path.sv ***
`include "txp_cfg.svh"

module test_tx_parallel_input_path;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] aw_addr = 8'h00;
  logic aw_valid = 1'b0;
  logic aw_ready;
  logic [31:0] w_data = 32'h0;
  logic [3:0] w_strb = 4'h0;
  logic w_valid = 1'b0;
  logic w_ready;
  logic [1:0] b_resp;
  logic b_valid;
  logic b_ready = 1'b0;
  logic [7:0] ar_addr = 8'h00;
  logic ar_valid = 1'b0;
  logic ar_ready;
  logic [31:0] r_data;
  logic [1:0] r_resp;
  logic r_valid;
  logic r_ready = 1'b0;
  logic [9:0] char_in;
  logic host_clk;
  logic ref_clk;
  logic [3:0] host_half = 4'h6;
  logic [9:0] tx_char;
  logic tx_stb;
  logic tx_err;
  logic [`TXP_MULT_W-1:0] pll_mult;
  logic irq;
  logic [9:0] chq[$];
  int n_errors = 0;
  int n_compared = 0;
  int seed = 32'hfaca;
  int reps;

  always #2 clk_i = !clk_i;

  txp_host_model host (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .host_half_i(host_half),
    .tx_char_in_o(char_in), .tx_host_input_clock_o(host_clk), .tx_reference_clock_o(ref_clk)
  );

  txp_top #(.DEPTH(8)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_ready),
    .s_axi_wdata_i(w_data), .s_axi_wstrb_i(w_strb), .s_axi_wvalid_i(w_valid),
    .s_axi_wready_o(w_ready), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid),
    .s_axi_bready_i(b_ready), .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid),
    .s_axi_arready_o(ar_ready), .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
    .s_axi_rvalid_o(r_valid), .s_axi_rready_i(r_ready),
    .tx_char_in_i(char_in), .tx_host_input_clock_i(host_clk), .tx_reference_clock_i(ref_clk),
    .tx_char_o(tx_char), .tx_char_stb_o(tx_stb), .tx_phase_error_o(tx_err),
    .tx_pll_mult_o(pll_mult), .irq_o(irq)
  );

  // every outgoing character is recorded
  always @(posedge clk_i) begin
    if (tx_stb === 1'b1) chq.push_back(tx_char);
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task stop_test;
    $display("counts: %0d compared, %0d mismatched", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    repeat ($unsigned($random(seed)) % 3) @(posedge clk_i);
    @(posedge clk_i);
    aw_addr <= a;
    aw_valid <= 1'b1;
    w_data <= d;
    w_strb <= {3'($random(seed)), 1'b1};
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    while (!done) begin
      @(posedge clk_i);
      if (aw_valid && aw_ready === 1'b1) aw_valid <= 1'b0;
      if (w_valid && w_ready === 1'b1) w_valid <= 1'b0;
      if (b_valid === 1'b1) begin
        done = 1'b1;
        b_ready <= 1'b0;
        check({30'h0, b_resp}, {30'h0, er});
      end
    end
  endtask : axi_wr

  task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    logic done;
    done = 1'b0;
    repeat ($unsigned($random(seed)) % 3) @(posedge clk_i);
    @(posedge clk_i);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    while (!done) begin
      @(posedge clk_i);
      if (ar_valid && ar_ready === 1'b1) ar_valid <= 1'b0;
      if (r_valid === 1'b1) begin
        done = 1'b1;
        r_ready <= 1'b0;
        check(r_data & m, e);
        check({30'h0, r_resp}, {30'h0, er});
      end
    end
  endtask : rd_chk

  task grab(input int n);
    int k;
    k = 0;
    chq.delete();
    while (chq.size() < n && k < 20000) begin
      @(posedge clk_i);
      k++;
    end
    check({31'h0, chq.size() >= n}, 32'h1);
  endtask : grab

  task wait_err(input logic v, input int lim);
    int k;
    k = 0;
    while (tx_err !== v && k < lim) begin
      @(posedge clk_i);
      k++;
    end
    check({31'h0, tx_err}, {31'h0, v});
  endtask : wait_err

  // characters after the settle count must follow the host counter
  task seq_chk(input int from);
    for (int i = from + 1; i < chq.size(); i++) begin
      check({22'h0, chq[i]}, {22'h0, 10'(chq[i-1] + 10'h001)});
    end
  endtask : seq_chk

  initial begin
    #200000;
    n_errors++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_chk(`TXP_ADDR_CTRL, 32'hFFFFFFFF, 32'h8, `TXP_RESP_OKAY);
    rd_chk(`TXP_ADDR_INT_STATUS, 32'hFFFFFFFF, 32'h0, `TXP_RESP_OKAY);
    rd_chk(`TXP_ADDR_INT_ENABLE, 32'hFFFFFFFF, 32'h0, `TXP_RESP_OKAY);
    rd_chk(`TXP_ADDR_INT_CLEAR, 32'hFFFFFFFF, 32'h0, `TXP_RESP_OKAY);
    rd_chk(8'h20, 32'hFFFFFFFF, 32'h0, `TXP_RESP_SLVERR);
    axi_wr(8'h20, 32'h0, `TXP_RESP_SLVERR);
    axi_wr(`TXP_ADDR_STATUS, 32'h1, `TXP_RESP_OKAY);
    rd_chk(`TXP_ADDR_STATUS, 32'h1, 32'h0, `TXP_RESP_OKAY);
    $display("test registers done");
    axi_wr(`TXP_ADDR_CTRL, 32'h0, `TXP_RESP_OKAY);
    grab(30);
    seq_chk(6);
    check({27'h0, pll_mult}, {27'h0, `TXP_MULT_FULL});
    chq.delete();
    repeat (240) @(posedge clk_i);
    reps = chq.size();
    check({31'h0, reps >= 19 && reps <= 21}, 32'h1);
    axi_wr(`TXP_ADDR_CTRL, 32'hB, `TXP_RESP_OKAY);
    repeat (8) @(posedge clk_i);
    check({27'h0, pll_mult}, {27'h0, `TXP_MULT_HALF});
    chq.delete();
    repeat (240) @(posedge clk_i);
    reps = chq.size();
    check({31'h0, reps >= 39 && reps <= 41}, 32'h1);
    $display("test rates done");
    axi_wr(`TXP_ADDR_CTRL, 32'h1, `TXP_RESP_OKAY);
    grab(30);
    seq_chk(6);
    host_half <= 4'h0;
    repeat (300) @(posedge clk_i);
    check({31'h0, tx_err}, 32'h0);
    $display("test bypass done");
    axi_wr(`TXP_ADDR_INT_CLEAR, 32'h3, `TXP_RESP_OKAY);
    axi_wr(`TXP_ADDR_INT_ENABLE, 32'h1, `TXP_RESP_OKAY);
    axi_wr(`TXP_ADDR_CTRL, 32'h8, `TXP_RESP_OKAY);
    wait_err(1'b1, 500);
    repeat (3) @(posedge clk_i);
    check({31'h0, irq}, 32'h1);
    rd_chk(`TXP_ADDR_INT_STATUS, 32'h1, 32'h1, `TXP_RESP_OKAY);
    grab(10);
    foreach (chq[i]) check({22'h0, chq[i]}, {22'h0, `TXP_ERR_CHAR});
    host_half <= 4'h6;
    repeat (300) @(posedge clk_i);
    check({31'h0, tx_err}, 32'h1);
    axi_wr(`TXP_ADDR_INT_CLEAR, 32'h1, `TXP_RESP_OKAY);
    repeat (3) @(posedge clk_i);
    check({31'h0, irq}, 32'h0);
    axi_wr(`TXP_ADDR_CTRL, 32'h0, `TXP_RESP_OKAY);
    wait_err(1'b0, 20);
    rd_chk(`TXP_ADDR_INT_STATUS, 32'h2, 32'h2, `TXP_RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    grab(30);
    seq_chk(6);
    host_half <= 4'h4;
    wait_err(1'b1, 600);
    host_half <= 4'h6;
    axi_wr(`TXP_ADDR_CTRL, 32'h0, `TXP_RESP_OKAY);
    wait_err(1'b0, 20);
    $display("test phase error done");
    axi_wr(`TXP_ADDR_CTRL, 32'hC, `TXP_RESP_OKAY);
    grab(520);
    reps = 0;
    for (int i = 2; i < 519; i++) begin
      check({31'h0, chq[i][0]}, {31'h0, chq[i][9] ^ chq[i][5]});
      check({23'h0, chq[i+1][9:1]}, {23'h0, chq[i][8:0]});
      if (i > 2 && i < 513 && chq[i] === chq[2]) reps++;
    end
    check({22'h0, chq[513]}, {22'h0, chq[2]});
    check(reps, 32'h0);
    $display("test self-test done");
    axi_wr(`TXP_ADDR_CTRL, 32'h8, `TXP_RESP_OKAY);
    rd_chk(`TXP_ADDR_CTRL, 32'hFFFFFFFF, 32'h8, `TXP_RESP_OKAY);
    rd_chk(`TXP_ADDR_STATUS, 32'h1, 32'h0, `TXP_RESP_OKAY);
    $display("test final done");
    stop_test();
  end
endmodule : test_tx_parallel_input_path
